//--- gpid_top.sv
// pin interrupt enable, latched status and data registers on wishbone
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
module gpid_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [gpid_pkg::ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // sideband pins
  input wire logic [gpid_pkg::PIN_N-1:0] i_pin_in,
  output logic [gpid_pkg::PIN_N-1:0] o_pin_out,
  output logic [gpid_pkg::PIN_N-1:0] o_pin_oe,
  // interrupt
  output logic o_irq
);
  logic rst_q1;
  logic rst_n;
  logic [15:0] ien;
  logic [15:0] status;
  logic [15:0] dat_out;
  logic [15:0] dir;
  logic [15:0] fsa;
  logic [15:0] fsb;
  logic [15:0] fsel_ok;
  logic [15:0] dir_eff;
  logic [15:0] valid;
  logic [15:0] set;
  logic [15:0] wmask;
  logic [15:0] wval;
  logic [15:0] rd_val;
  logic [15:0] clr_rd;
  logic [15:0] clr_wr;
  logic [15:0] next_status;
  logic req;
  logic commit;
  logic wr;
  logic rd;

  gpid_sync_if sif ();

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  gpid_pin_sync u_sync (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .sif(sif.sync_side)
  );

  assign sif.raw = {4'h0, i_pin_in};

  // word index hit; low two address bits are byte offset
  function automatic logic fn_hit(input logic [gpid_pkg::ADR_W-1:0] adr,
                                  input logic [15:0] idx);
    fn_hit = (adr[gpid_pkg::ADR_W-1:2] == idx);
  endfunction

  // bus handshake: ack a cycle after the request, drop it the cycle after
  assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign commit = i_wb_cyc && i_wb_stb && o_wb_ack;
  assign wr = commit && i_wb_we;
  assign rd = commit && !i_wb_we;
  assign wmask = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  assign wval = i_wb_dat[15:0] & wmask;

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_wb_ack <= 1'b0;
    else
      o_wb_ack <= req;
  end

  // pins 0 to 3 have no function select and are always in gpio mode; reserved pin 9 never is
  always_comb
  begin
    fsel_ok = gpid_pkg::FREE_MASK;
    fsel_ok[gpid_pkg::BIT_SCL] = fsb[gpid_pkg::FS_SCL];
    fsel_ok[gpid_pkg::BIT_SDA] = fsb[gpid_pkg::FS_SDA];
    fsel_ok[gpid_pkg::BIT_TXD] = fsb[gpid_pkg::FS_TXD];
    fsel_ok[gpid_pkg::BIT_LOCK] = fsa[gpid_pkg::FS_LOCK];
    fsel_ok[gpid_pkg::BIT_MULTIPURPOSE_CTL] = fsa[gpid_pkg::FS_MULTIPURPOSE_CTL];
    fsel_ok[gpid_pkg::BIT_INDICATOR_ONE] = fsa[gpid_pkg::FS_INDICATOR_ONE];
    fsel_ok[gpid_pkg::BIT_INDICATOR_ZERO] = fsa[gpid_pkg::FS_INDICATOR_ZERO];
  end

  // direction acts only under the select; status only counts as input
  assign dir_eff = fsel_ok & dir & gpid_pkg::PIN_MASK;
  assign valid = fsel_ok & ~dir & gpid_pkg::PIN_MASK;
  assign set = sif.change & valid;

  // drive only while the pin is an enabled output
  assign o_pin_oe = dir_eff[gpid_pkg::PIN_N-1:0];
  assign o_pin_out = dat_out[gpid_pkg::PIN_N-1:0];

  // enable register
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      ien <= gpid_pkg::RST_IEN;
    else if (wr && fn_hit(i_wb_adr, gpid_pkg::IDX_IEN))
      ien <= ((ien & ~wmask) | wval) & gpid_pkg::PIN_MASK;
  end

  // direction register
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      dir <= gpid_pkg::RST_DIR;
    else if (wr && fn_hit(i_wb_adr, gpid_pkg::IDX_DIR))
      dir <= ((dir & ~wmask) | wval) & gpid_pkg::PIN_MASK;
  end

  // function select registers
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fsa <= gpid_pkg::RST_FS;
      fsb <= gpid_pkg::RST_FS;
    end
    else if (wr)
    begin
      if (fn_hit(i_wb_adr, gpid_pkg::IDX_FSA))
        fsa <= ((fsa & ~wmask) | wval) & gpid_pkg::FSA_MASK;
      if (fn_hit(i_wb_adr, gpid_pkg::IDX_FSB))
        fsb <= ((fsb & ~wmask) | wval) & gpid_pkg::FSB_MASK;
    end
  end

  // output register: a write always lands, the pin follows only if driven
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      dat_out <= gpid_pkg::RST_DAT;
    else if (wr && fn_hit(i_wb_adr, gpid_pkg::IDX_DAT))
      dat_out <= ((dat_out & ~wmask) | wval) & gpid_pkg::PIN_MASK;
  end

  // clears: status read clears what it returned, clear register by write
  assign clr_rd = (rd && fn_hit(i_wb_adr, gpid_pkg::IDX_IST)) ? o_wb_dat[15:0] : 16'h0000;
  assign clr_wr = (wr && fn_hit(i_wb_adr, gpid_pkg::IDX_CLR)) ? wval : 16'h0000;
  // an event in the clearing cycle wins, so none is lost
  assign next_status = ((status & ~clr_rd & ~clr_wr) | set) & gpid_pkg::PIN_MASK;

  // latched-high status
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      status <= gpid_pkg::RST_IST;
    else
      status <= next_status;
  end

  // read mux; data reads the pin while input, the register while output
  always_comb
  begin
    rd_val = 16'h0000;
    if (fn_hit(i_wb_adr, gpid_pkg::IDX_IEN))
      rd_val = ien;
    else if (fn_hit(i_wb_adr, gpid_pkg::IDX_IST))
      rd_val = status;
    else if (fn_hit(i_wb_adr, gpid_pkg::IDX_DAT))
      rd_val = ((dir_eff & dat_out) | (~dir_eff & sif.level)) & gpid_pkg::PIN_MASK;
    else if (fn_hit(i_wb_adr, gpid_pkg::IDX_DIR))
      rd_val = dir;
    else if (fn_hit(i_wb_adr, gpid_pkg::IDX_FSA))
      rd_val = fsa;
    else if (fn_hit(i_wb_adr, gpid_pkg::IDX_FSB))
      rd_val = fsb;
  end

  // read data captured with the ack; unmapped and write cycles return zero
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_wb_dat <= 32'h00000000;
    else if (req && !i_wb_we)
      o_wb_dat <= {16'h0000, rd_val};
    else if (req)
      o_wb_dat <= 32'h00000000;
  end

  // interrupt level; invalid bits are masked so stale latches stay quiet
  assign o_irq = |(status & ien & valid);

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!rst_n);

  property p_ien_rsv;
    (ien & ~gpid_pkg::PIN_MASK) == 16'h0000;
  endproperty
  a_ien_rsv: assert property (p_ien_rsv) else $error("reserved enable bit set");

  property p_st_set;
    (set != 16'h0000) |=> ((status & $past(set)) == $past(set));
  endproperty
  a_st_set: assert property (p_st_set) else $error("event did not latch status");

  property p_st_only_valid;
    1'b1 |=> ((status & ~$past(status) & ~$past(valid)) == 16'h0000);
  endproperty
  a_st_only_valid: assert property (p_st_only_valid) else $error("invalid pin set status");

  property p_st_rd_clear;
    (rd && fn_hit(i_wb_adr, gpid_pkg::IDX_IST)) |=>
      ((status & $past(o_wb_dat[15:0]) & ~$past(set)) == 16'h0000);
  endproperty
  a_st_rd_clear: assert property (p_st_rd_clear) else $error("status read did not clear");

  property p_scl_oe;
    o_pin_oe[gpid_pkg::BIT_SCL] |-> (fsb[gpid_pkg::FS_SCL] && dir[gpid_pkg::BIT_SCL]);
  endproperty
  a_scl_oe: assert property (p_scl_oe) else $error("clock pin driven without select");

  property p_scl_wr;
    (wr && fn_hit(i_wb_adr, gpid_pkg::IDX_DAT) && i_wb_sel[1] && dir_eff[gpid_pkg::BIT_SCL])
      |=> (o_pin_out[gpid_pkg::BIT_SCL] == $past(i_wb_dat[gpid_pkg::BIT_SCL]))
        && o_pin_oe[gpid_pkg::BIT_SCL];
  endproperty
  a_scl_wr: assert property (p_scl_wr) else $error("clock pin write not driven");

  property p_scl_rd_in;
    (req && !i_wb_we && fn_hit(i_wb_adr, gpid_pkg::IDX_DAT) && !dir_eff[gpid_pkg::BIT_SCL])
      |=> (o_wb_dat[gpid_pkg::BIT_SCL] == $past(sif.level[gpid_pkg::BIT_SCL]));
  endproperty
  a_scl_rd_in: assert property (p_scl_rd_in) else $error("input read not the pin");

  property p_free_oe;
    o_pin_oe[gpid_pkg::BIT_GPIO] == dir[gpid_pkg::BIT_GPIO];
  endproperty
  a_free_oe: assert property (p_free_oe) else $error("gpio direction not followed");

  // an enabled event raises the line next cycle unless software reconfigures
  property p_irq;
    (((set & ien) != 16'h0000) && !wr) |=> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled status without interrupt");

  property p_ack_pulse;
    o_wb_ack |=> !o_wb_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

  property p_ack_req;
    (i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack;
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("request not acked next cycle");

  property p_dat_hi;
    o_wb_dat[31:16] == 16'h0000;
  endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("upper read data not zero");

  property p_st_rsv;
    (status & ~gpid_pkg::PIN_MASK) == 16'h0000;
  endproperty
  a_st_rsv: assert property (p_st_rsv) else $error("reserved status bit set");

  // a latched bit may only fall through a status read or a clear write
  property p_st_hold;
    1'b1 |=> ((~status & $past(status) & ~$past(clr_rd | clr_wr)) == 16'h0000);
  endproperty
  a_st_hold: assert property (p_st_hold) else $error("status bit lost without clear");

  property p_st_ro;
    (wr && fn_hit(i_wb_adr, gpid_pkg::IDX_IST)) |=>
      (status == ($past(status) | $past(set)));
  endproperty
  a_st_ro: assert property (p_st_ro) else $error("status changed by a write");

  property p_clr_wr;
    (wr && fn_hit(i_wb_adr, gpid_pkg::IDX_CLR)) |=>
      ((status & $past(wval) & ~$past(set)) == 16'h0000);
  endproperty
  a_clr_wr: assert property (p_clr_wr) else $error("clear write did not clear");

  // validity checked against the select and direction bits themselves; the gpio pin, having no select, against direction alone
  property p_sda_valid;
    $rose(status[gpid_pkg::BIT_SDA]) |->
      ($past(fsb[gpid_pkg::FS_SDA]) && !$past(dir[gpid_pkg::BIT_SDA]));
  endproperty
  a_sda_valid: assert property (p_sda_valid) else $error("data pin latched invalid");

  property p_txd_valid;
    $rose(status[gpid_pkg::BIT_TXD]) |->
      ($past(fsb[gpid_pkg::FS_TXD]) && !$past(dir[gpid_pkg::BIT_TXD]));
  endproperty
  a_txd_valid: assert property (p_txd_valid) else $error("tx-disable latched invalid");

  property p_lock_valid;
    $rose(status[gpid_pkg::BIT_LOCK]) |->
      ($past(fsa[gpid_pkg::FS_LOCK]) && !$past(dir[gpid_pkg::BIT_LOCK]));
  endproperty
  a_lock_valid: assert property (p_lock_valid) else $error("lock pin latched invalid");

  property p_gpio_valid;
    $rose(status[gpid_pkg::BIT_GPIO]) |-> !$past(dir[gpid_pkg::BIT_GPIO]);
  endproperty
  a_gpio_valid: assert property (p_gpio_valid) else $error("gpio latched as output");

  property p_scl_rd_out;
    (req && !i_wb_we && fn_hit(i_wb_adr, gpid_pkg::IDX_DAT) && fsb[gpid_pkg::FS_SCL]
      && dir[gpid_pkg::BIT_SCL]) |=> (o_wb_dat[gpid_pkg::BIT_SCL] == $past(dat_out[gpid_pkg::BIT_SCL]));
  endproperty
  a_scl_rd_out: assert property (p_scl_rd_out) else $error("output read not the register");

  property p_scl_wr_in;
    (wr && fn_hit(i_wb_adr, gpid_pkg::IDX_DAT) && i_wb_sel[1] && !dir_eff[gpid_pkg::BIT_SCL])
      |=> !o_pin_oe[gpid_pkg::BIT_SCL] && (dat_out[gpid_pkg::BIT_SCL] == $past(i_wb_dat[11]));
  endproperty
  a_scl_wr_in: assert property (p_scl_wr_in) else $error("input write drove the pin");

  property p_sda_oe;
    o_pin_oe[gpid_pkg::BIT_SDA] |-> (fsb[gpid_pkg::FS_SDA] && dir[gpid_pkg::BIT_SDA]);
  endproperty
  a_sda_oe: assert property (p_sda_oe) else $error("data pin driven without select");

  property p_ind_oe;
    o_pin_oe[gpid_pkg::BIT_INDICATOR_ZERO] |->
      (fsa[gpid_pkg::FS_INDICATOR_ZERO] && dir[gpid_pkg::BIT_INDICATOR_ZERO]);
  endproperty
  a_ind_oe: assert property (p_ind_oe) else $error("indicator driven without select");

  property p_dir_rsv;
    (dir & ~gpid_pkg::PIN_MASK) == 16'h0000;
  endproperty
  a_dir_rsv: assert property (p_dir_rsv) else $error("reserved direction bit set");

  property p_irq_off;
    ((status & ien) == 16'h0000) |-> !o_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt without enabled status");

  c_irq: cover property (o_irq ##1 (rd && fn_hit(i_wb_adr, gpid_pkg::IDX_IST)) ##1 !o_irq);
  c_scl_drive: cover property (wr && dir_eff[gpid_pkg::BIT_SCL]);
  c_set_and_clr: cover property ((set & clr_rd) != 16'h0000);
  c_clr_wr: cover property (clr_wr != 16'h0000);
endmodule

//--- gpid_pkg.sv
// constants of the pin interrupt and data block
package gpid_pkg;
  localparam int ADR_W = 18;
  localparam int PIN_N = 12;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_IEN = 16'hF010;
  localparam logic [15:0] IDX_IST = 16'hF011;
  localparam logic [15:0] IDX_DAT = 16'hF012;
  localparam logic [15:0] IDX_DIR = 16'hF013;
  localparam logic [15:0] IDX_FSA = 16'hF015;
  localparam logic [15:0] IDX_FSB = 16'hF016;
  localparam logic [15:0] IDX_CLR = 16'hF017;
  // pin bit positions
  localparam int BIT_SCL = 11;
  localparam int BIT_SDA = 10;
  localparam int BIT_TXD = 8;
  localparam int BIT_LOCK = 7;
  localparam int BIT_MULTIPURPOSE_CTL = 6;
  localparam int BIT_INDICATOR_ONE = 5;
  localparam int BIT_INDICATOR_ZERO = 4;
  localparam int BIT_GPIO = 3;
  // function select positions (FSB: clock, data, tx-disable; FSA: the rest)
  localparam int FS_SCL = 15;
  localparam int FS_SDA = 11;
  localparam int FS_TXD = 3;
  localparam int FS_LOCK = 15;
  localparam int FS_MULTIPURPOSE_CTL = 11;
  localparam int FS_INDICATOR_ONE = 7;
  localparam int FS_INDICATOR_ZERO = 3;
  // masks of implemented bits
  localparam logic [15:0] PIN_MASK = 16'h0DFF;
  localparam logic [15:0] FREE_MASK = 16'h000F;
  localparam logic [15:0] FSA_MASK = 16'h8888;
  localparam logic [15:0] FSB_MASK = 16'h8808;
  // reset values
  localparam logic [15:0] RST_IEN = 16'h0000;
  localparam logic [15:0] RST_IST = 16'h0000;
  localparam logic [15:0] RST_DAT = 16'h0100;
  localparam logic [15:0] RST_DIR = 16'h0C00;
  localparam logic [15:0] RST_FS = 16'h0000;
endpackage

//--- gpid_sync_if.sv
// carrier between the pin synchroniser and the register block
`timescale 1ns/1ps
interface gpid_sync_if;
  logic [15:0] raw;
  logic [15:0] level;
  logic [15:0] change;
  modport sync_side (input raw, output level, output change);
  modport user_side (output raw, input level, input change);
endinterface

//--- gpid_pin_sync.sv
// three-stage pin synchroniser with debounced level and change pulse
`timescale 1ns/1ps
module gpid_pin_sync (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // pins in, level and change out
  gpid_sync_if.sync_side sif
);
  for (genvar i = 0; i < 16; i++)
  begin : g_bit
    logic s1;
    logic s2;
    logic s3;
    logic stab;
    logic chg;
    logic primed;
    // s1 feeds s2 only; a change counts once s2 and s3 agree
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
      if (!i_rst_n)
      begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
      end
      else
      begin
        s1 <= sif.raw[i];
        s2 <= s1;
        s3 <= s2;
      end
    end
    // first agreement after reset silently loads the reset zeros of s2 and s3, so a strapped
    // high pin still looks like an event once it reaches s2 and s3
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
      if (!i_rst_n)
      begin
        stab <= 1'b0;
        chg <= 1'b0;
        primed <= 1'b0;
      end
      else
      begin
        chg <= 1'b0;
        if (s2 == s3)
        begin
          stab <= s3;
          primed <= 1'b1;
          chg <= primed && (s3 != stab);
        end
      end
    end
    assign sif.level[i] = stab;
    assign sif.change[i] = chg;
  end
endmodule

//--- gpid_pin_model.sv
// pluggable module and indicator side of the sideband pins
`timescale 1ns/1ps
module gpid_pin_model (
  // levels the device puts out
  input wire logic [gpid_pkg::PIN_N-1:0] i_pin_out,
  input wire logic [gpid_pkg::PIN_N-1:0] i_pin_oe,
  // levels the module side holds on undriven pins
  input wire logic [gpid_pkg::PIN_N-1:0] i_level,
  // resolved wire level
  output logic [gpid_pkg::PIN_N-1:0] o_pin
);
  // the device wins where it drives; elsewhere the module level shows, never a stale copy
  always_comb
  begin
    o_pin = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_level);
  end
endmodule

//--- gpid_top_tb.sv
// self-checking bench for the pin interrupt and data block
`timescale 1ns/1ps
module gpid_top_tb;
  logic i_clk;
  logic i_resetn;
  logic cyc;
  logic stb;
  logic we;
  logic [gpid_pkg::ADR_W-1:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic ack;
  logic [11:0] pin_in;
  logic [11:0] pin_out;
  logic [11:0] pin_oe;
  logic [11:0] level;
  logic irq;
  logic [31:0] rv;
  int err_count;
  int check_count;

  gpid_top dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_irq(irq)
  );

  gpid_pin_model pins (.i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_level(level), .o_pin(pin_in));

  // free-running 100 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task complete_run;
    $display("errors %0d, checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // one classic cycle; the request stands until ack is sampled high
  task wb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= d;
    sel <= 4'hF;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    rv = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1)
    begin
      $display("mismatch at %0t: no ack", $time);
      err_count++;
      complete_run();
    end
    else
      @(negedge i_clk); // let the commit edge settle before callers sample outputs
  endtask

  // register read result against expectation under a mask
  task chk_reg(input logic [15:0] idx, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, idx, 32'h0);
    check_count++;
    if ((rv & m) !== e)
    begin
      $display("mismatch at %0t: reg %h read %h want %h", $time, idx, rv, e);
      err_count++;
    end
  endtask

  // pin or flag output, looked at once settled
  task chk_sig(input logic [11:0] got, input logic [11:0] e);
    @(negedge i_clk);
    check_count++;
    if (got !== e)
    begin
      $display("mismatch at %0t: output %h want %h", $time, got, e);
      err_count++;
    end
  endtask

  // flip module-side levels and give the synchroniser time to report
  task flip(input logic [11:0] m);
    @(posedge i_clk);
    level <= level ^ m;
    repeat (6) @(posedge i_clk);
  endtask

  initial
  begin
    i_resetn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    sel = 4'h0;
    wdat = 32'h0;
    level = 12'h000;
    err_count = 0;
    check_count = 0;
    repeat (8) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (6) @(posedge i_clk);
    // reset values
    chk_reg(gpid_pkg::IDX_IEN, 32'hFFFFFFFF, 32'h0);
    chk_reg(gpid_pkg::IDX_IST, 32'hFFFFFFFF, 32'h0);
    chk_reg(gpid_pkg::IDX_DIR, 32'hFFFFFFFF, 32'h0C00);
    chk_sig(pin_oe, 12'h000);
    chk_sig(pin_out, 12'h100);
    // reserved enable bit 9, read-only status, unmapped place
    wb(1'b1, gpid_pkg::IDX_IEN, 32'hFFFF);
    chk_reg(gpid_pkg::IDX_IEN, 32'hFFFFFFFF, 32'h0DFF);
    wb(1'b1, gpid_pkg::IDX_IST, 32'hFFFF);
    chk_reg(gpid_pkg::IDX_IST, 32'hFFFFFFFF, 32'h0);
    chk_reg(16'hF014, 32'hFFFFFFFF, 32'h0);
    // clock pin: output only once its select is set
    wb(1'b1, gpid_pkg::IDX_DAT, 32'h0800);
    chk_sig(pin_oe, 12'h000);
    wb(1'b1, gpid_pkg::IDX_FSB, 32'h8000);
    chk_sig(pin_oe & pin_out, 12'h800);
    wb(1'b1, gpid_pkg::IDX_DAT, 32'h0000);
    chk_sig(pin_oe & ~pin_out, 12'h800);
    wb(1'b1, gpid_pkg::IDX_DAT, 32'h0800);
    chk_reg(gpid_pkg::IDX_DAT, 32'h0800, 32'h0800);
    // turning it to input releases it; the pin falls and that counts as an event
    wb(1'b1, gpid_pkg::IDX_DIR, 32'h0000);
    chk_sig(pin_oe, 12'h000);
    repeat (6) @(posedge i_clk);
    chk_reg(gpid_pkg::IDX_DAT, 32'h0800, 32'h0);
    chk_sig({11'h0, irq}, 12'h001);
    chk_reg(gpid_pkg::IDX_IST, 32'hFFFFFFFF, 32'h0800);
    chk_sig({11'h0, irq}, 12'h000);
    // gated pins with selects still clear do not latch
    flip(12'h5F0);
    chk_reg(gpid_pkg::IDX_IST, 32'hFFFFFFFF, 32'h0);
    wb(1'b1, gpid_pkg::IDX_FSA, 32'h8888);
    wb(1'b1, gpid_pkg::IDX_FSB, 32'h8808);
    flip(12'hDF0);
    chk_reg(gpid_pkg::IDX_IST, 32'hFFFFFFFF, 32'h0DF0);
    // free pins need only input direction; enable masks the interrupt
    flip(12'h00F);
    wb(1'b1, gpid_pkg::IDX_IEN, 32'h0);
    chk_sig({11'h0, irq}, 12'h000);
    wb(1'b1, gpid_pkg::IDX_IEN, 32'h0008);
    chk_sig({11'h0, irq}, 12'h001);
    wb(1'b1, gpid_pkg::IDX_CLR, 32'h0001);
    chk_reg(gpid_pkg::IDX_CLR, 32'hFFFFFFFF, 32'h0);
    chk_reg(gpid_pkg::IDX_IST, 32'hFFFFFFFF, 32'h000E);
    chk_reg(gpid_pkg::IDX_IST, 32'hFFFFFFFF, 32'h0);
    // free pins set as output ignore the far side
    wb(1'b1, gpid_pkg::IDX_DIR, 32'h000F);
    chk_sig(pin_oe, 12'h00F);
    flip(12'h00F);
    chk_reg(gpid_pkg::IDX_IST, 32'hFFFFFFFF, 32'h0);
    complete_run();
  end

  // cut a hang short
  initial
  begin
    #500000;
    $display("mismatch at %0t: run limit", $time);
    err_count++;
    complete_run();
  end
endmodule
